// ===== sacq_pkg.sv
// Shared constants and carrier types for the servo converter acquisition block.
// Assumes a single 10 MHz aclk domain and an AXI4-Lite register master.
package sacq_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_LF_GAIN = 8'h00;
  localparam logic [7:0] OFS_MUX_CTRL = 8'h04;
  localparam logic [7:0] OFS_RF_GAIN = 8'h08;
  localparam logic [7:0] OFS_RF_TRIM = 8'h0C;
  localparam logic [7:0] OFS_RF_MONFLT = 8'h10;
  localparam logic [7:0] OFS_RF_PWRDN = 8'h14;
  localparam logic [7:0] OFS_RF_BYPASS = 8'h18;
  localparam logic [7:0] OFS_OFFS_CTRL = 8'h1C;
  localparam logic [7:0] OFS_GP_TRIM = 8'h20;
  localparam logic [7:0] OFS_GP_STAT = 8'h24;
  localparam logic [7:0] OFS_GP_VAL0 = 8'h28;
  localparam logic [7:0] OFS_GP_VAL1 = 8'h2C;
  localparam logic [7:0] OFS_LF_FILT0 = 8'h30;
  // Field positions
  localparam int MUX_AUX_BIT = 0;
  localparam int MUX_GP_SEL_BIT = 1;
  localparam int GAIN1_LSB = 4;
  localparam int MONSEL_LSB = 4;
  localparam int BYPASS_BIT = 1;
  localparam int OFFS_MEAS_BIT = 0;
  localparam int OFFS_LASER_BIT = 1;
  localparam int GP_TRIM_EN_BIT = 31;
  // Reset values
  localparam logic [3:0] LF_GAIN_RST = 4'h0;
  localparam logic [7:0] RF_GAIN_RST = 8'h00;
  localparam logic [5:0] RF_TRIM_RST = 6'h00;
  localparam logic [6:0] RF_MONFLT_RST = 7'h00;
  localparam logic [5:0] RF_PWRDN_RST = 6'h3F;
  // Timing: PDM rate 4 MHz sampled at 10 MHz
  localparam int CLK_HZ = 10_000_000;
  localparam int PDM_HZ = 4_000_000;
  localparam int PDM_PER_CYC = CLK_HZ / PDM_HZ;
  localparam int FILT_SH = 4;
  localparam int DEC_LEN = 256;
  localparam int GP_BITS = 10;
  localparam int LF_CH = 6;
  localparam int GP_CH = 2;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [3:0] gain1;
    logic [3:0] gain2;
  } sacq_rf_gain_t;

  typedef struct packed {
    logic [7:0] gain;
    logic [5:0] trim;
    logic [2:0] monsel;
    logic [3:0] rolloff;
    logic [5:0] pwrdn;
    logic ext_bypass;
  } sacq_rf_ctrl_t;
endpackage

// ===== sacq_top.sv
// Servo converter acquisition control: PDM capture, offset removal, filtering,
// decimation of general purpose channels and RF path control registers.
// Assumes PDM bits arrive asynchronously and an AXI4-Lite master on aclk.
`timescale 1ns/1ps
module sacq_top import sacq_pkg::*; (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Sync reset, active low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [LF_CH-1:0] lf_pdm_in, // PDM bits from LF converters
  input wire logic [GP_CH-1:0] gp_pdm_in, // PDM bits from GP converters
  input wire logic laser_on, // Laser state, async level
  output logic [LF_CH-1:0] lf_pdm_out, // Offset-corrected PDM streams to servo
  output logic [LF_CH-1:0] lf_pdm_valid, // One pulse per PDM slot, every second cycle (5 MHz)
  output logic signed [15:0] diff_ab, // diode_a minus diode_b
  output logic signed [15:0] diff_cd, // diode_c minus diode_d
  output logic signed [15:0] diff_spot, // side_spot_one minus side_spot_two
  output logic [3:0] lf_converter_gain, // Feedback current select
  output logic lf1_aux_select, // LF1 takes aux_left/right pair
  output logic gp_input_select, // GP inputs 2 and 3 chosen
  output sacq_rf_ctrl_t rf_ctrl, // RF analog path controls
  output logic [GP_CH-1:0] gp_irq // Per-channel new value request
);

  typedef enum logic [2:0] {
    W_IDLE = 3'b001,
    W_RESP = 3'b010,
    W_HOLD = 3'b100
  } sacq_wr_t;

  // Saturating signed 16-bit subtract, used for offsets and differences
  function automatic logic signed [15:0] sub_sat(input logic signed [15:0] a,
                                                  input logic signed [15:0] b);
    logic signed [16:0] s;
    s = 17'(a) - 17'(b);
    if (s > 17'sd32767) sub_sat = 16'sh7FFF;
    else if (s < -17'sd32768) sub_sat = 16'sh8000;
    else sub_sat = s[15:0];
  endfunction

  logic [LF_CH-1:0] lf_s1_q, lf_s2_q;
  logic [GP_CH-1:0] gp_s1_q, gp_s2_q;
  logic las_s1_q, las_s2_q;
  logic [3:0] lf_gain_q;
  logic [1:0] mux_q;
  sacq_rf_gain_t rf_gain_q;
  logic [5:0] rf_trim_q;
  logic [6:0] rf_monflt_q;
  logic [5:0] rf_pwrdn_q;
  logic [1:0] rf_bypass_q;
  logic offs_meas_q;
  logic [31:0] gp_trim_q;
  logic [1:0] slot_q;
  logic slot_tick;
  logic signed [15:0] lf_filt_q [LF_CH];
  logic signed [15:0] lf_offs_q [LF_CH];
  logic signed [15:0] lf_corr [LF_CH];
  logic [LF_CH-1:0] lf_out_q;
  logic signed [15:0] gp_filt_q [GP_CH];
  logic [15:0] gp_acc_q [GP_CH];
  logic [7:0] dec_cnt_q;
  logic [GP_BITS-1:0] gp_val_q [GP_CH];
  logic [GP_CH-1:0] gp_new_q;
  sacq_wr_t wst_q;
  logic aw_hold_q, w_hold_q;
  logic [7:0] awa_q;
  logic [31:0] wd_q;
  logic [3:0] ws_q;
  logic wr_fire;
  logic wr_ok;
  logic [GP_CH-1:0] gp_clr;
  logic [31:0] rd_d;
  logic rd_ok;

  // Two-stage synchronisers for converter bits and laser level
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_s1_q <= '0;
      lf_s2_q <= '0;
      gp_s1_q <= '0;
      gp_s2_q <= '0;
      las_s1_q <= 1'b0;
      las_s2_q <= 1'b0;
    end else begin
      lf_s1_q <= lf_pdm_in;
      lf_s2_q <= lf_s1_q;
      gp_s1_q <= gp_pdm_in;
      gp_s2_q <= gp_s1_q;
      las_s1_q <= laser_on;
      las_s2_q <= las_s1_q;
    end
  end

  // slot timer; 10/4 MHz rounds to one slot every two cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) slot_q <= '0;
    else if (slot_q == 2'(PDM_PER_CYC - 1)) slot_q <= '0;
    else slot_q <= slot_q + 2'h1;
  end
  assign slot_tick = (slot_q == 2'h0);

  // first-order low-pass per LF stream (bit maps to +/-4096)
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LF_CH; i++) lf_filt_q[i] <= '0;
    end else if (slot_tick) begin
      for (int i = 0; i < LF_CH; i++)
        lf_filt_q[i] <= lf_filt_q[i] +
          ((lf_s2_q[i] ? 16'sh1000 : -16'sh1000) - lf_filt_q[i]) / 16'sd16;
    end
  end

  // stored offsets only follow while measuring with laser off
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < LF_CH; i++) lf_offs_q[i] <= '0;
    end else if (offs_meas_q && !las_s2_q && slot_tick) begin
      for (int i = 0; i < LF_CH; i++) lf_offs_q[i] <= lf_filt_q[i];
    end
  end

  // subtract offset when laser is on; re-quantise to a PDM bit
  always_comb begin
    for (int i = 0; i < LF_CH; i++)
      lf_corr[i] = las_s2_q ? sub_sat(lf_filt_q[i], lf_offs_q[i]) : lf_filt_q[i];
  end

  // corrected bit streams, one per LF converter
  always_ff @(posedge aclk) begin
    if (!aresetn) lf_out_q <= '0;
    else if (slot_tick) begin
      for (int i = 0; i < LF_CH; i++) lf_out_q[i] <= !lf_corr[i][15];
    end
  end
  assign lf_pdm_out = lf_out_q;
  assign lf_pdm_valid = {LF_CH{slot_tick}};

  // servo difference signals from filtered, corrected channels
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diff_ab <= '0;
      diff_cd <= '0;
      diff_spot <= '0;
    end else begin
      diff_ab <= sub_sat(lf_corr[0], lf_corr[1]);
      diff_cd <= sub_sat(lf_corr[2], lf_corr[3]);
      diff_spot <= sub_sat(lf_corr[4], lf_corr[5]);
    end
  end

  // GP low-pass, and decimating accumulate of the synchronised bits with optional trim
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int j = 0; j < GP_CH; j++) begin
        gp_filt_q[j] <= '0;
        gp_acc_q[j] <= '0;
        gp_val_q[j] <= '0;
      end
      dec_cnt_q <= '0;
    end else if (slot_tick) begin
      for (int j = 0; j < GP_CH; j++)
        gp_filt_q[j] <= gp_filt_q[j] +
          ((gp_s2_q[j] ? 16'sh1000 : -16'sh1000) - gp_filt_q[j]) / 16'sd16;
      dec_cnt_q <= dec_cnt_q + 8'h01;
      for (int j = 0; j < GP_CH; j++) begin
        if (dec_cnt_q == 8'(DEC_LEN - 1)) begin
          gp_acc_q[j] <= '0;
          gp_val_q[j] <= gp_acc_q[j][15:6];
        end else begin
          gp_acc_q[j] <= gp_acc_q[j] + 16'(gp_s2_q[j]) +
            (gp_trim_q[GP_TRIM_EN_BIT] ? 16'(gp_trim_q[j*8 +: 8]) : 16'h0000);
        end
      end
    end
  end

  // new-value flags; capture wins over a read clear
  always_ff @(posedge aclk) begin
    if (!aresetn) gp_new_q <= '0;
    else begin
      for (int j = 0; j < GP_CH; j++) begin
        if (slot_tick && dec_cnt_q == 8'(DEC_LEN - 1)) gp_new_q[j] <= 1'b1;
        else if (gp_clr[j]) gp_new_q[j] <= 1'b0;
      end
    end
  end
  assign gp_irq = gp_new_q;

  // AXI write channel: address and data taken in either order
  assign s_axi_awready = (wst_q == W_IDLE) && !aw_hold_q;
  assign s_axi_wready = (wst_q == W_IDLE) && !w_hold_q;
  assign wr_fire = (wst_q == W_IDLE) &&
    (aw_hold_q || s_axi_awvalid) && (w_hold_q || s_axi_wvalid);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q <= W_IDLE;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      unique case (wst_q)
        W_IDLE: begin
          if (s_axi_awvalid && !aw_hold_q) begin
            aw_hold_q <= 1'b1;
            awa_q <= s_axi_awaddr[7:0];
          end
          if (s_axi_wvalid && !w_hold_q) begin
            w_hold_q <= 1'b1;
            wd_q <= s_axi_wdata;
            ws_q <= s_axi_wstrb;
          end
          if (wr_fire) wst_q <= W_HOLD;
        end
        W_HOLD: begin
          aw_hold_q <= 1'b0;
          w_hold_q <= 1'b0;
          s_axi_bvalid <= 1'b1;
          s_axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
          wst_q <= W_RESP;
        end
        W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wst_q <= W_IDLE;
          end
        end
        default: wst_q <= W_IDLE;
      endcase
    end
  end

  // Decode the held write address
  always_comb begin
    unique case (awa_q)
      OFS_LF_GAIN, OFS_MUX_CTRL, OFS_RF_GAIN, OFS_RF_TRIM, OFS_RF_MONFLT,
      OFS_RF_PWRDN, OFS_RF_BYPASS, OFS_OFFS_CTRL, OFS_GP_TRIM: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Control registers; only byte lane 0 matters except the trim word
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lf_gain_q <= LF_GAIN_RST;
      mux_q <= '0;
      rf_gain_q <= RF_GAIN_RST;
      rf_trim_q <= RF_TRIM_RST;
      rf_monflt_q <= RF_MONFLT_RST;
      rf_pwrdn_q <= RF_PWRDN_RST;
      rf_bypass_q <= '0;
      offs_meas_q <= 1'b0;
      gp_trim_q <= '0;
    end else if (wst_q == W_HOLD && ws_q[0]) begin
      unique case (awa_q)
        OFS_LF_GAIN: lf_gain_q <= wd_q[3:0];
        OFS_MUX_CTRL: mux_q <= wd_q[1:0];
        OFS_RF_GAIN: rf_gain_q <= wd_q[7:0];
        // sign in bit 5, magnitude in 4:0
        OFS_RF_TRIM: rf_trim_q <= wd_q[5:0];
        // rolloff and monitor in one word
        OFS_RF_MONFLT: rf_monflt_q <= wd_q[6:0];
        OFS_RF_PWRDN: rf_pwrdn_q <= wd_q[5:0];
        OFS_RF_BYPASS: rf_bypass_q <= wd_q[1:0];
        OFS_OFFS_CTRL: offs_meas_q <= wd_q[OFFS_MEAS_BIT];
        OFS_GP_TRIM: gp_trim_q <= {wd_q[31], 15'h0000, wd_q[15:0]};
        default: ;
      endcase
    end
  end

  // Control outputs to the analog side
  assign lf_converter_gain = lf_gain_q;
  assign lf1_aux_select = mux_q[MUX_AUX_BIT];
  // GP inputs 2/3 in place of 0/1
  assign gp_input_select = mux_q[MUX_GP_SEL_BIT];
  assign rf_ctrl.gain = rf_gain_q;
  assign rf_ctrl.trim = rf_trim_q;
  assign rf_ctrl.monsel = rf_monflt_q[MONSEL_LSB +: 3];
  assign rf_ctrl.rolloff = rf_monflt_q[3:0];
  assign rf_ctrl.pwrdn = rf_pwrdn_q;
  // monitor pin becomes RF input; 6-bit converter is analog
  assign rf_ctrl.ext_bypass = rf_bypass_q[BYPASS_BIT];

  // Read mux; status shows flags, offsets and converter state
  always_comb begin
    rd_d = 32'h0000_0000;
    rd_ok = 1'b1;
    gp_clr = '0;
    unique case (s_axi_araddr[7:0])
      OFS_LF_GAIN: rd_d[3:0] = lf_gain_q;
      OFS_MUX_CTRL: rd_d[1:0] = mux_q;
      OFS_RF_GAIN: rd_d[7:0] = rf_gain_q;
      OFS_RF_TRIM: rd_d[5:0] = rf_trim_q;
      OFS_RF_MONFLT: rd_d[6:0] = rf_monflt_q;
      OFS_RF_PWRDN: rd_d[5:0] = rf_pwrdn_q;
      OFS_RF_BYPASS: rd_d[1:0] = rf_bypass_q;
      OFS_OFFS_CTRL: rd_d[1:0] = {las_s2_q, offs_meas_q};
      OFS_GP_TRIM: rd_d = gp_trim_q;
      OFS_GP_STAT: rd_d[1:0] = gp_new_q;
      OFS_GP_VAL0: begin
        rd_d[GP_BITS-1:0] = gp_val_q[0];
        gp_clr[0] = s_axi_arvalid && s_axi_arready;
      end
      OFS_GP_VAL1: begin
        rd_d[GP_BITS-1:0] = gp_val_q[1];
        gp_clr[1] = s_axi_arvalid && s_axi_arready;
      end
      OFS_LF_FILT0: rd_d[15:0] = lf_offs_q[0];
      default: rd_ok = 1'b0;
    endcase
  end

  // AXI read channel: one read at a time, answer one cycle after taking
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_d;
      s_axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

// ===== sacq_sva.sv
// Port checks for the servo acquisition block.
// Assumes one aclk domain; bound onto every sacq_top.
`timescale 1ns/1ps
module sacq_sva import sacq_pkg::*; (
  input wire logic aclk, // Clock
  input wire logic aresetn, // Sync reset
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Aw valid
  input wire logic s_axi_awready, // Aw ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Strobes
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // Ar valid
  input wire logic s_axi_arready, // Ar ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [LF_CH-1:0] lf_pdm_valid, // Slot ticks
  input wire sacq_rf_ctrl_t rf_ctrl // RF controls
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Address and data taken together, then the gain write itself
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_gain_wr;
    s_wr_taken ##0 (s_axi_awaddr[7:0] == OFS_RF_GAIN && s_axi_wstrb[0]);
  endsequence

  a_slot_period: assert property (lf_pdm_valid[0] |=> !lf_pdm_valid[0] ##1 lf_pdm_valid[0])
    else $error("slot tick not every second cycle");
  // Slot phase after reset, all channels on the same tick
  a_slot_aligned: assert property ($rose(aresetn) |-> lf_pdm_valid == {LF_CH{1'b1}})
    else $error("slot ticks not aligned after reset");
  // Taken edge, one hold cycle, then the response
  a_write_latency: assert property (s_wr_taken |-> !s_axi_bvalid ##1 !s_axi_bvalid ##1 s_axi_bvalid)
    else $error("write response not two cycles after request");
  a_aw_busy: assert property (s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address channel ready while write open");
  a_bvalid_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response held after handshake");
  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data not one cycle after request");
  a_rvalid_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data held after handshake");
  a_arready_busy: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
    else $error("read address ready while read open");
  a_gain_write: assert property (s_gain_wr |-> ##2 rf_ctrl.gain == $past(s_axi_wdata[7:0], 2))
    else $error("RF gain not updated by write");
endmodule

bind sacq_top sacq_sva u_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .lf_pdm_valid(lf_pdm_valid), .rf_ctrl(rf_ctrl));

// ===== sacq_pickup_model.sv
// Behavioural pickup and converter bit sources for the acquisition block.
// Assumes the bench paces it with aclk; bits move on the falling edge.
`timescale 1ns/1ps
module sacq_pickup_model (
  input wire logic aclk, // Pacing clock
  input wire logic laser_cmd, // Laser enable from bench
  input wire logic [11:0] lf_mode, // Per diode: 0 low, 1 high, 2 toggling
  input wire logic [3:0] gp_mode, // Same coding per GP input
  output logic [5:0] lf_pdm, // LF converter bits
  output logic [1:0] gp_pdm, // GP converter bits
  output logic laser_on // Laser state
);
  logic ph;

  function automatic logic pick(input logic [1:0] m, input logic p);
    return (m == 2'h1) || (m == 2'h2 && p);
  endfunction

  // Defined levels before the first falling edge
  initial begin
    ph = 1'b0;
    lf_pdm = 6'h00;
    gp_pdm = 2'h0;
    laser_on = 1'b0;
  end

  // Falling edge so bits look unrelated to the sampling edge
  always @(negedge aclk) begin
    ph <= !ph;
    laser_on <= laser_cmd;
    for (int i = 0; i < 6; i++) begin
      lf_pdm[i] <= laser_on ? pick(lf_mode[2*i +: 2], ph) : 1'b1; // Dark level is full scale
    end
    for (int i = 0; i < 2; i++) begin
      gp_pdm[i] <= pick(gp_mode[2*i +: 2], ph);
    end
  end
endmodule

// ===== tb_top.sv
// Self-checking bench for the servo acquisition block.
// Assumes a 10 MHz aclk, AXI4-Lite master tasks and the pickup model.
`timescale 1ns/1ps
module tb_top import sacq_pkg::*; ;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [31:0] exp;
  } sacq_row_t;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, gp_pdm, gp_irq;
  logic [31:0] s_axi_rdata, rd, rd0;
  logic [5:0] lf_pdm, lf_pdm_valid, lf_pdm_out;
  logic laser_on, laser_cmd = 1'b0, lf1_aux_select, gp_input_select;
  logic [11:0] lf_mode = 12'h000;
  logic [3:0] gp_mode = 4'h1;
  logic [3:0] lf_converter_gain;
  logic signed [15:0] diff_ab, diff_cd, diff_spot;
  sacq_rf_ctrl_t rf_ctrl;
  int compares = 0, miscompares = 0, cycles = 0, n;
  sacq_row_t rows [8] = '{'{OFS_LF_GAIN, 32'hA, 32'hA}, '{OFS_MUX_CTRL, 32'h1, 32'h1},
    '{OFS_MUX_CTRL, 32'h2, 32'h2}, '{OFS_RF_GAIN, 32'hA5, 32'hA5},
    '{OFS_RF_TRIM, 32'h25, 32'h25}, '{OFS_RF_MONFLT, 32'h5C, 32'h5C},
    '{OFS_RF_PWRDN, 32'h15, 32'h15}, '{OFS_RF_BYPASS, 32'h2, 32'h2}};

  sacq_pickup_model u_model (.aclk(aclk), .laser_cmd(laser_cmd), .lf_mode(lf_mode),
    .gp_mode(gp_mode), .lf_pdm(lf_pdm), .gp_pdm(gp_pdm), .laser_on(laser_on));

  sacq_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .lf_pdm_in(lf_pdm), .gp_pdm_in(gp_pdm), .laser_on(laser_on),
    .lf_pdm_out(lf_pdm_out), .lf_pdm_valid(lf_pdm_valid), .diff_ab(diff_ab), .diff_cd(diff_cd),
    .diff_spot(diff_spot), .lf_converter_gain(lf_converter_gain),
    .lf1_aux_select(lf1_aux_select), .gp_input_select(gp_input_select), .rf_ctrl(rf_ctrl),
    .gp_irq(gp_irq));

  // 100 ns period
  always #50 aclk = !aclk;

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wrap_up();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Address and data offered together, each dropped when taken
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    logic aw_open;
    logic w_open;
    @(posedge aclk);
    s_axi_awaddr <= {24'h0, a};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_open = 1'b1;
    w_open = 1'b1;
    while (aw_open || w_open) begin
      @(posedge aclk);
      if (aw_open && s_axi_awready) begin
        s_axi_awvalid <= 1'b0;
        aw_open = 1'b0;
      end
      if (w_open && s_axi_wready) begin
        s_axi_wvalid <= 1'b0;
        w_open = 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  // Field seen at the ports for a register offset
  function automatic logic [31:0] seen_field(input logic [7:0] a);
    case (a)
      OFS_LF_GAIN: return {28'h0, lf_converter_gain};
      OFS_MUX_CTRL: return {30'h0, gp_input_select, lf1_aux_select};
      OFS_RF_GAIN: return {24'h0, rf_ctrl.gain};
      OFS_RF_TRIM: return {26'h0, rf_ctrl.trim};
      OFS_RF_MONFLT: return {25'h0, rf_ctrl.monsel, rf_ctrl.rolloff};
      OFS_RF_PWRDN: return {26'h0, rf_ctrl.pwrdn};
      default: return {30'h0, rf_ctrl.ext_bypass, 1'b0};
    endcase
  endfunction

  // Hang guard: far beyond the longest expected run
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 6000) begin
      miscompares++;
      wrap_up();
    end
  end

  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("rf_ctrl reset", 32'(rf_ctrl), 32'({22'h0, RF_PWRDN_RST, 1'b0}));
    check("gp_irq reset", {30'h0, gp_irq}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      axi_write(rows[i].addr, rows[i].data, 4'hF, resp);
      check("write resp", {30'h0, resp}, {30'h0, RESP_OKAY});
      check("port field", seen_field(rows[i].addr), rows[i].exp);
      axi_read(rows[i].addr, rd, resp);
      check("readback", rd, rows[i].exp);
    end
    // Dropped strobe and unmapped places
    axi_write(OFS_RF_GAIN, 32'h33, 4'h0, resp);
    check("no strobe gain", {24'h0, rf_ctrl.gain}, 32'hA5);
    axi_write(8'h3C, 32'h1, 4'hF, resp);
    check("unmapped wr", {30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_read(8'h3C, rd, resp);
    check("unmapped rd", {rd[29:0], resp}, {30'h0, RESP_SLVERR});
    n = 0;
    repeat (100) begin
      @(negedge aclk);
      n += lf_pdm_valid[0];
    end
    check("slot ticks", n, 50);
    // Dark measurement, then laser on with measurement frozen
    axi_write(OFS_OFFS_CTRL, 32'h1, 4'hF, resp);
    repeat (300) @(posedge aclk);
    axi_read(OFS_LF_FILT0, rd0, resp);
    check("dark offset", {31'h0, rd0 != 0}, 32'h1);
    axi_write(OFS_OFFS_CTRL, 32'h0, 4'hF, resp);
    lf_mode <= 12'h415;
    laser_cmd <= 1'b1;
    repeat (300) @(posedge aclk);
    axi_read(OFS_LF_FILT0, rd, resp);
    check("offset held", rd, rd0);
    axi_read(OFS_OFFS_CTRL, rd, resp);
    check("laser seen", {31'h0, rd[OFFS_LASER_BIT]}, 32'h1);
    check("diff_ab", 32'(diff_ab), 32'h0);
    check("diff_cd sign", {31'h0, diff_cd > 0}, 32'h1);
    check("diff_spot sign", {31'h0, diff_spot < 0}, 32'h1);
    // Lit channels sit on the dark offset, dark ones fall below it
    check("pdm out", {26'h0, lf_pdm_out}, 32'h27);
    // GP capture: full scale on channel 0, empty on channel 1
    axi_read(OFS_GP_VAL0, rd, resp);
    n = 0;
    while (gp_irq[0] !== 1'b1 && n < 1200) begin
      @(negedge aclk);
      n++;
    end
    check("gp irq set", {31'h0, gp_irq[0]}, 32'h1);
    axi_read(OFS_GP_VAL0, rd0, resp);
    @(negedge aclk);
    check("gp irq clear", {31'h0, gp_irq[0]}, 32'h0);
    check("gp0 width", {rd0[31:GP_BITS], rd0 != 0}, 32'h1);
    axi_read(OFS_GP_VAL1, rd, resp);
    check("gp1 below gp0", {31'h0, rd < rd0}, 32'h1);
    // Fine trim on channel 1 only; the second capture spans a whole window
    axi_write(OFS_GP_TRIM, 32'h8000_4000, 4'hF, resp);
    axi_read(OFS_GP_TRIM, rd, resp);
    check("gp trim rb", rd, 32'h8000_4000);
    repeat (2) begin
      axi_read(OFS_GP_VAL1, rd, resp);
      n = 0;
      while (gp_irq[1] !== 1'b1 && n < 1200) begin
        @(negedge aclk);
        n++;
      end
    end
    check("gp1 irq set", {31'h0, gp_irq[1]}, 32'h1);
    axi_read(OFS_GP_VAL1, rd, resp);
    check("gp1 trimmed", rd, 32'h0000_00FF);
    wrap_up();
  end
endmodule
